/* rtl/pin_change_detector.sv */
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - edges keep setting flags with master enable clear; no interrupt until set
// - each pin has a rising-edge detector gated by its rising enable bit
// - each pin has a falling-edge detector gated by its falling enable bit
// - both enable bits set means edges of either polarity are detected
// - every pin of both ports is enabled independently
// - enabled edge sets pin flag; interrupt raised when master enable set
// - read-only summary bit is high whenever any pin flag is set
// - writing zero to a flag bit clears it
// - edge arriving during a flag write leaves that flag set
// - in sleep, a pin-change interrupt wakes the device if enabled
// - edges seen in sleep are in the flags before wake completes
module pin_change_detector
   import pin_change_pkg::*;
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [pin_change_pkg::PORT_WIDTH-1:0] first_port_i,
   input wire logic [pin_change_pkg::PORT_WIDTH-1:0] second_port_i,
   input wire logic [5:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [5:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic irq_o,
   output logic wake_o
);
   import pin_change_pkg::*;

   logic pin_change_irq_enable;
   logic sleep_request;
   logic [PORT_WIDTH-1:0] rise_first;
   logic [PORT_WIDTH-1:0] fall_first;
   logic [PORT_WIDTH-1:0] rise_second;
   logic [PORT_WIDTH-1:0] fall_second;
   logic [PIN_COUNT-1:0] pin_flags;
   logic [PIN_COUNT-1:0] rising_edge_enable_reg;
   logic [PIN_COUNT-1:0] falling_edge_enable_reg;
   logic [PIN_COUNT-1:0] flag_clear;
   logic [PIN_COUNT-1:0] pin_vector;
   logic [1:0] irq_mask;
   logic [1:0] irq_status;
   logic pin_change_summary_flag;
   logic interrupt_event;
   bus_state_t bus_state;
   logic aw_held;
   logic w_held;
   logic [5:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [31:0] next_rdata;
   logic next_rerr;
   logic werr;

   assign pin_vector = {second_port_i, first_port_i};
   assign rising_edge_enable_reg = {rise_second, rise_first};
   assign falling_edge_enable_reg = {fall_second, fall_first};

   // one detector per pin, each with its own enables
   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++) begin : g_pin
         pin_edge_capture u_pin (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .pin_i(pin_vector[g]),
            .sleep_i(sleep_request),
            .rise_en_i(rising_edge_enable_reg[g]),
            .fall_en_i(falling_edge_enable_reg[g]),
            .clear_i(flag_clear[g]),
            .flag_o(pin_flags[g])
         );
      end
   endgenerate

   // summary and interrupt event
   assign pin_change_summary_flag = |pin_flags;
   assign interrupt_event = pin_change_summary_flag && pin_change_irq_enable;

   // write path: address and data taken in either order
   assign do_write = aw_held && w_held && (bus_state == BUS_IDLE);

   // flag clears: a written zero with its byte lane strobed
   always_comb begin
      flag_clear = '0;
      if (do_write && w_strb[0]) begin
         if (aw_addr == ADDR_FLAGS_FIRST) begin
            flag_clear[PORT_WIDTH-1:0] = ~w_data[PORT_WIDTH-1:0];
         end
         if (aw_addr == ADDR_FLAGS_SECOND) begin
            flag_clear[PIN_COUNT-1:PORT_WIDTH] = ~w_data[PORT_WIDTH-1:0];
         end
      end
   end

   // write address and data capture
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // ready flags: accept each channel once per transaction
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_arready_o <= 1'b0;
      end else begin
         s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
         s_axi_wready_o <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o);
         s_axi_arready_o <= (bus_state == BUS_IDLE) && !do_write &&
                            !(s_axi_arvalid_i && s_axi_arready_o);
      end
   end

   // configuration registers, lane 0 only
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pin_change_irq_enable <= 1'b0;
         sleep_request <= 1'b0;
         rise_first <= PORT_RESET;
         fall_first <= PORT_RESET;
         rise_second <= PORT_RESET;
         fall_second <= PORT_RESET;
         irq_mask <= '0;
      end else begin
         if (do_write && w_strb[0]) begin
            case (aw_addr)
               ADDR_CONTROL: begin
                  pin_change_irq_enable <= w_data[CTRL_ENABLE_BIT];
                  sleep_request <= w_data[CTRL_SLEEP_BIT];
               end
               ADDR_RISE_FIRST: rise_first <= w_data[PORT_WIDTH-1:0];
               ADDR_FALL_FIRST: fall_first <= w_data[PORT_WIDTH-1:0];
               ADDR_RISE_SECOND: rise_second <= w_data[PORT_WIDTH-1:0];
               ADDR_FALL_SECOND: fall_second <= w_data[PORT_WIDTH-1:0];
               ADDR_IRQ_MASK: irq_mask <= w_data[1:0];
               default: begin
               end
            endcase
         end
         if (sleep_request && interrupt_event) begin
            sleep_request <= 1'b0;
         end
      end
   end

   // write-one-to-clear status: bit0 pin change, bit1 wake; set wins
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         irq_status <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == 0 && interrupt_event) ||
                (i == 1 && sleep_request && interrupt_event)) begin
               irq_status[i] <= 1'b1;
            end else if (do_write && w_strb[0] && aw_addr == ADDR_STATUS &&
                         w_data[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
      end
   end

   // interrupt and wake outputs
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask) || interrupt_event;
         wake_o <= sleep_request && interrupt_event;
      end
   end

   // write error for unmapped addresses
   always_comb begin
      case (aw_addr)
         ADDR_CONTROL, ADDR_RISE_FIRST, ADDR_FALL_FIRST, ADDR_FLAGS_FIRST,
         ADDR_RISE_SECOND, ADDR_FALL_SECOND, ADDR_FLAGS_SECOND, ADDR_IRQ_MASK,
         ADDR_STATUS: werr = 1'b0;
         default: werr = 1'b1;
      endcase
   end

   // read mux
   always_comb begin
      next_rdata = '0;
      next_rerr = 1'b0;
      case (s_axi_araddr_i)
         ADDR_CONTROL: begin
            next_rdata[CTRL_ENABLE_BIT] = pin_change_irq_enable;
            next_rdata[CTRL_SUMMARY_BIT] = pin_change_summary_flag;
            next_rdata[CTRL_SLEEP_BIT] = sleep_request;
         end
         ADDR_RISE_FIRST: next_rdata[PORT_WIDTH-1:0] = rise_first;
         ADDR_FALL_FIRST: next_rdata[PORT_WIDTH-1:0] = fall_first;
         ADDR_FLAGS_FIRST: next_rdata[PORT_WIDTH-1:0] = pin_flags[PORT_WIDTH-1:0];
         ADDR_RISE_SECOND: next_rdata[PORT_WIDTH-1:0] = rise_second;
         ADDR_FALL_SECOND: next_rdata[PORT_WIDTH-1:0] = fall_second;
         ADDR_FLAGS_SECOND: next_rdata[PORT_WIDTH-1:0] = pin_flags[PIN_COUNT-1:PORT_WIDTH];
         ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
         ADDR_STATUS: next_rdata[1:0] = irq_status;
         default: next_rerr = 1'b1;
      endcase
   end

   // response state machine
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         bus_state <= BUS_IDLE;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rresp_o <= RESP_OKAY;
         s_axi_rdata_o <= '0;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (do_write) begin
                  s_axi_bvalid_o <= 1'b1;
                  s_axi_bresp_o <= werr ? RESP_SLVERR : RESP_OKAY;
                  bus_state <= BUS_WRITE_RESP;
               end else if (s_axi_arvalid_i && s_axi_arready_o) begin
                  s_axi_rvalid_o <= 1'b1;
                  s_axi_rdata_o <= next_rdata;
                  s_axi_rresp_o <= next_rerr ? RESP_SLVERR : RESP_OKAY;
                  bus_state <= BUS_READ_RESP;
               end
            end
            BUS_WRITE_RESP: begin
               if (s_axi_bready_i) begin
                  s_axi_bvalid_o <= 1'b0;
                  bus_state <= BUS_IDLE;
               end
            end
            BUS_READ_RESP: begin
               if (s_axi_rready_i) begin
                  s_axi_rvalid_o <= 1'b0;
                  bus_state <= BUS_IDLE;
               end
            end
            default: bus_state <= BUS_IDLE;
         endcase
      end
   end

   a_irq_needs_enable: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (!pin_change_irq_enable && irq_status == 2'h0) |=> !irq_o)
      else $error("interrupt without master enable");
   a_summary_tracks: assert property (@(posedge clk_i) disable iff (!rstn_i)
      pin_change_summary_flag == (pin_flags != '0))
      else $error("summary mismatch");
   a_wake_on_irq: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (sleep_request && interrupt_event) |=> (wake_o && !sleep_request))
      else $error("no wake on interrupt");
   a_reset_clears: assert property (@(posedge clk_i)
      !rstn_i |=> (pin_flags == '0 && rising_edge_enable_reg == '0 &&
                   falling_edge_enable_reg == '0))
      else $error("reset left state");
   a_clear_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (flag_clear[0] && !g_pin[0].u_pin.edge_hit && !g_pin[0].u_pin.sleep_hit) |=>
      !pin_flags[0])
      else $error("flag not cleared");
   a_write_answer: assert property (@(posedge clk_i) disable iff (!rstn_i)
      do_write |=> s_axi_bvalid_o) else $error("write not answered");
   a_read_answer: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (s_axi_arvalid_i && s_axi_arready_o && !do_write) |=> s_axi_rvalid_o)
      else $error("read not answered");
   a_irq_on_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (pin_change_irq_enable && pin_change_summary_flag) |=> irq_o)
      else $error("missing interrupt");
endmodule

/* rtl/pin_change_pkg.sv */
package pin_change_pkg;
   // port geometry
   localparam int PORT_WIDTH = 8;
   localparam int PIN_COUNT = 16;
   // register byte addresses
   localparam logic [5:0] ADDR_CONTROL = 6'h00;
   localparam logic [5:0] ADDR_RISE_FIRST = 6'h04;
   localparam logic [5:0] ADDR_FALL_FIRST = 6'h08;
   localparam logic [5:0] ADDR_FLAGS_FIRST = 6'h0C;
   localparam logic [5:0] ADDR_RISE_SECOND = 6'h10;
   localparam logic [5:0] ADDR_FALL_SECOND = 6'h14;
   localparam logic [5:0] ADDR_FLAGS_SECOND = 6'h18;
   localparam logic [5:0] ADDR_IRQ_MASK = 6'h1C;
   localparam logic [5:0] ADDR_STATUS = 6'h20;
   // control register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SUMMARY_BIT = 1;
   localparam int CTRL_SLEEP_BIT = 2;
   // port reset value and bus response codes
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // bus slave states
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRITE_RESP = 3'b010,
      BUS_READ_RESP = 3'b100
   } bus_state_t;
endpackage

/* rtl/pin_edge_capture.sv */
`timescale 1ns/10ps
// one pin: synchroniser, edge detect, sleep capture and flag
module pin_edge_capture (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic pin_i,
   input wire logic sleep_i,
   input wire logic rise_en_i,
   input wire logic fall_en_i,
   input wire logic clear_i,
   output logic flag_o
);
   logic sync_first;
   logic sync_second;
   logic last_level;
   logic sleep_ref;
   logic sleep_seen;
   logic edge_hit;
   logic sleep_hit;

   // two stage synchroniser, first stage read only by the second
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sync_first <= 1'b0;
         sync_second <= 1'b0;
         last_level <= 1'b0;
      end else begin
         sync_first <= pin_i;
         sync_second <= sync_first;
         last_level <= sync_second;
      end
   end

   // enabled edge of either polarity
   always_comb begin
      edge_hit = (rise_en_i && sync_second && !last_level) ||
                 (fall_en_i && !sync_second && last_level);
   end

   // sleep capture: level held at sleep entry, any enabled change is kept
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sleep_ref <= 1'b0;
         sleep_seen <= 1'b0;
      end else if (!sleep_i) begin
         sleep_ref <= sync_second;
         sleep_seen <= 1'b0;
      end else if ((rise_en_i && sync_second && !sleep_ref) ||
                   (fall_en_i && !sync_second && sleep_ref)) begin
         sleep_seen <= 1'b1;
      end
   end
   assign sleep_hit = sleep_seen && !sleep_i;

   // flag: set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         flag_o <= 1'b0;
      end else if (edge_hit || sleep_hit) begin
         flag_o <= 1'b1;
      end else if (clear_i) begin
         flag_o <= 1'b0;
      end
   end

   a_set_wins_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (edge_hit && clear_i) |=> flag_o) else $error("flag lost on clear");
endmodule

/* sim/pin_source.sv */
`timescale 1ns/10ps
// far-side pin drivers: levels move off the clock grid, as real pins do
module pin_source (
   input wire logic [7:0] first_req_i,
   input wire logic [7:0] second_req_i,
   output logic [7:0] first_port_o,
   output logic [7:0] second_port_o
);
   // start low, then follow requests with a skew unrelated to the clock
   initial begin
      first_port_o = 8'h00;
      second_port_o = 8'h00;
   end
   always @(first_req_i) first_port_o <= #1.3 first_req_i;
   always @(second_req_i) second_port_o <= #2.1 second_req_i;
endmodule

/* sim/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import pin_change_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] first_req = 8'h00;
   logic [7:0] second_req = 8'h00;
   logic [7:0] first_port;
   logic [7:0] second_port;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, wake, seen;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd_data;
   logic [5:0] regs [7] = '{ADDR_CONTROL, ADDR_RISE_FIRST, ADDR_FALL_FIRST, ADDR_FLAGS_FIRST,
      ADDR_RISE_SECOND, ADDR_FALL_SECOND, ADDR_IRQ_MASK};
   int bad_count = 0;
   int total_checks = 0;
   // free-running 250 MHz clock
   always #2 clk_i = ~clk_i;
   pin_source pins_far (.first_req_i(first_req), .second_req_i(second_req),
      .first_port_o(first_port), .second_port_o(second_port));
   pin_change_detector dut (.clk_i(clk_i), .rstn_i(rstn_i), .first_port_i(first_port),
      .second_port_i(second_port), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .irq_o(irq), .wake_o(wake));
   // word compare; single bits are widened into it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // address and data offered together, each dropped once taken
   task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic expect_reg(input logic [5:0] a, input logic [31:0] e);
      axi_read(a, rd_data, resp);
      chk(rd_data, e);
      chk({30'h0, resp}, {30'h0, RESP_OKAY});
   endtask
   // new pin levels, then time for sync, flag and irq to settle
   task automatic pins(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_i);
      first_req <= a;
      second_req <= b;
      repeat (8) @(posedge clk_i);
   endtask
   // raise pin 0 of the first port during sleep and watch for the wake pulse
   task automatic sleep_edge(input logic [31:0] ctrl);
      pins(8'hFC, 8'h00);
      axi_write(ADDR_FLAGS_FIRST, 32'h00, resp);
      axi_write(ADDR_CONTROL, ctrl, resp);
      first_req <= 8'hFD;
      seen = 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_i);
         if (wake === 1'b1) seen = 1'b1;
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (6000) @(posedge clk_i);
      bad_count++;
      give_verdict;
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      foreach (regs[k]) expect_reg(regs[k], 32'h0);
      // unmapped place answers with an error on both paths
      axi_read(6'h24, rd_data, resp);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      axi_write(6'h24, 32'hFF, resp);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      // rising detector only; flags kept with master enable clear
      axi_write(ADDR_RISE_FIRST, 32'h01, resp);
      pins(8'h01, 8'h00);
      expect_reg(ADDR_FLAGS_FIRST, 32'h01);
      chk_bit(irq, 1'b0);
      expect_reg(ADDR_CONTROL, 32'h2);
      axi_write(ADDR_FLAGS_FIRST, 32'h00, resp);
      expect_reg(ADDR_FLAGS_FIRST, 32'h00);
      pins(8'h00, 8'h00);
      expect_reg(ADDR_FLAGS_FIRST, 32'h00);
      // falling detector on the second port
      axi_write(ADDR_FALL_SECOND, 32'h08, resp);
      pins(8'h00, 8'h08);
      expect_reg(ADDR_FLAGS_SECOND, 32'h00);
      pins(8'h00, 8'h00);
      expect_reg(ADDR_FLAGS_SECOND, 32'h08);
      expect_reg(ADDR_CONTROL, 32'h2);
      axi_write(ADDR_FLAGS_SECOND, 32'h00, resp);
      // both polarities on one pin
      axi_write(ADDR_RISE_FIRST, 32'h80, resp);
      axi_write(ADDR_FALL_FIRST, 32'h80, resp);
      pins(8'h80, 8'h00);
      expect_reg(ADDR_FLAGS_FIRST, 32'h80);
      axi_write(ADDR_FLAGS_FIRST, 32'h00, resp);
      pins(8'h00, 8'h00);
      expect_reg(ADDR_FLAGS_FIRST, 32'h80);
      // independent pins, then a masked clear that keeps a fresh edge
      axi_write(ADDR_RISE_FIRST, 32'h55, resp);
      axi_write(ADDR_FALL_FIRST, 32'h02, resp);
      axi_write(ADDR_FLAGS_FIRST, 32'h00, resp);
      pins(8'hFF, 8'h00);
      axi_read(ADDR_FLAGS_FIRST, rd_data, resp);
      chk(rd_data, 32'h55);
      pins(8'hFD, 8'h00);
      axi_write(ADDR_FLAGS_FIRST, rd_data ^ 32'hFF, resp);
      expect_reg(ADDR_FLAGS_FIRST, 32'h02);
      // interrupt output follows the master enable
      chk_bit(irq, 1'b0);
      axi_write(ADDR_CONTROL, 32'h1, resp);
      repeat (2) @(posedge clk_i);
      chk_bit(irq, 1'b1);
      expect_reg(ADDR_CONTROL, 32'h3);
      axi_write(ADDR_FLAGS_FIRST, 32'h00, resp);
      expect_reg(ADDR_CONTROL, 32'h1);
      axi_write(ADDR_IRQ_MASK, 32'h3, resp);
      expect_reg(ADDR_IRQ_MASK, 32'h3);
      axi_write(ADDR_STATUS, 32'h3, resp);
      repeat (2) @(posedge clk_i);
      chk_bit(irq, 1'b0);
      // edge landing while the flag register is written
      axi_write(ADDR_RISE_FIRST, 32'h01, resp);
      pins(8'hFC, 8'h00);
      first_req <= 8'hFD;
      axi_write(ADDR_FLAGS_FIRST, 32'h00, resp);
      expect_reg(ADDR_FLAGS_FIRST, 32'h01);
      // sleep without master enable: flagged but no wake
      sleep_edge(32'h4);
      chk_bit(seen, 1'b0);
      expect_reg(ADDR_FLAGS_FIRST, 32'h01);
      // sleep with master enable: wake, flag already recorded
      sleep_edge(32'h5);
      chk_bit(seen, 1'b1);
      expect_reg(ADDR_FLAGS_FIRST, 32'h01);
      expect_reg(ADDR_CONTROL, 32'h3);
      give_verdict;
   end
endmodule
